// ==== shared/rsb_map.svh ====
`ifndef RSB_MAP_SVH
`define RSB_MAP_SVH

`define RSB_CLK_HZ      25000000
`define RSB_BAUD_BPS    500000
`define RSB_BIT_CYC     (`RSB_CLK_HZ / `RSB_BAUD_BPS)
`define RSB_DIV_LAST    6'(`RSB_BIT_CYC - 1)

`define RSB_WORD_W      16
`define RSB_IMG_WORDS   256
`define RSB_MAX_SLAVES  6'h20
`define RSB_MIN_SLAVES  6'h01
`define RSB_SLV_WORDS   8
`define RSB_SLV_BITS    128

`define RSB_CRC_POLY    16'h1021
`define RSB_CRC_INIT    16'hFFFF
`define RSB_LINE_IDLE   1'b1

`endif

// ==== shared/rsb_pkg.sv ====
`include "rsb_map.svh"

package rsb_pkg;

	typedef enum logic [2:0] {
		RSB_M_IDLE  = 3'b000,
		RSB_M_CRC   = 3'b001,
		RSB_M_SHIFT = 3'b010,
		RSB_M_LATCH = 3'b011,
		RSB_M_FBK   = 3'b100
	} rsb_mst_st_e;

	typedef struct packed {
		rsb_mst_st_e st;
		logic [5:0]  div;
		logic [12:0] cnt;
		logic [8:0]  nw;
		logic [15:0] crc;
		logic [15:0] rxw;
		logic        tx;
		logic        bad;
		logic        crc_err;
		logic        line_err;
		logic        done;
	} rsb_mst_s;

	typedef struct packed {
		logic [127:0] sr;
		logic [127:0] outw;
		logic         fb_act;
		logic         bad;
		logic         line_err;
	} rsb_slv_s;

	// one serial step of the ring check word, message bit first into the top
	function automatic logic [15:0] rsb_crc_step(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[15] ^ b;
		return {c[14:0], 1'b0} ^ (fb ? `RSB_CRC_POLY : 16'h0000);
	endfunction

endpackage

// ==== shared/rsb_link_if.sv ====
`timescale 1ns/100ps

interface rsb_link_if;
	logic data_out;
	logic data_out_n;
	logic serial_rx_line;
	logic serial_rx_line_inverted;
	logic bit_tick;
	logic latch;
	logic fallback;

	modport master (
		output data_out,
		output data_out_n,
		output bit_tick,
		output latch,
		output fallback,
		input  serial_rx_line,
		input  serial_rx_line_inverted
	);

	modport slave (
		input  data_out,
		input  data_out_n,
		input  bit_tick,
		input  latch,
		input  fallback,
		output serial_rx_line,
		output serial_rx_line_inverted
	);
endinterface

// ==== src/rsb_slave.sv ====
`timescale 1ns/100ps
`include "rsb_map.svh"

module rsb_slave
	import rsb_pkg::*;
(
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	rsb_link_if.slave         link,
	input  wire logic [127:0] i_in_words,
	input  wire logic         i_fallback_en,
	input  wire logic [127:0] i_fallback_words,
	input  wire logic         i_last,
	output logic      [127:0] o_out_words,
	output logic              o_fallback_active,
	output logic              o_line_err,
	output logic              o_dn_data,
	output logic              o_dn_data_n,
	output logic              o_dn_tick,
	output logic              o_dn_latch,
	output logic              o_dn_fallback,
	input  wire logic         i_dn_ret,
	input  wire logic         i_dn_ret_n
);

	rsb_slv_s r;
	rsb_slv_s n;

	always_comb begin
		n = r;
		if (link.bit_tick) begin
			n.sr = {r.sr[126:0], link.data_out};
			if (link.data_out == link.data_out_n) begin
				n.bad = 1'b1;
			end
		end
		if (link.latch) begin
			n.outw     = r.sr;
			n.sr       = i_in_words;
			n.fb_act   = 1'b0;
			n.line_err = r.bad;
			n.bad      = 1'b0;
		end
		if (link.fallback && i_fallback_en) begin
			n.outw   = i_fallback_words;
			n.fb_act = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// the last module closes the ring, the others carry the return back upstream
	assign link.serial_rx_line          = i_last ? r.sr[127] : i_dn_ret;
	assign link.serial_rx_line_inverted = i_last ? ~r.sr[127] : i_dn_ret_n;

	assign o_dn_data         = r.sr[127];
	assign o_dn_data_n       = ~r.sr[127];
	assign o_dn_tick         = link.bit_tick;
	assign o_dn_latch        = link.latch;
	assign o_dn_fallback     = link.fallback;
	assign o_out_words       = r.outw;
	assign o_fallback_active = r.fb_act;
	assign o_line_err        = r.line_err;

endmodule

// ==== src/rsb_master.sv ====
// Behaviour
// - master drives ring out, receives last slave's return
// - whole ring acts as one shift register
// - each slave regenerates the stream it forwards
// - slave swaps its slice for own data
// - bits shift at 500 kbit/s from clock
// - image holds 256 input, 256 output words
// - up to 32 slaves, addresses 1 to 32
// - address follows position, nearest slave is 1
// - run to stop commands slaves to fallback values
// - outgoing and returning paths are separate, simultaneous
// - both paths are differential, true and inverted
`timescale 1ns/100ps
`include "rsb_map.svh"

module rsb_master
	import rsb_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	rsb_link_if.master       link,
	input  wire logic        i_run,
	input  wire logic [5:0]  i_slave_cnt,
	input  wire logic        i_wr_en,
	input  wire logic [7:0]  i_wr_addr,
	input  wire logic [15:0] i_wr_data,
	input  wire logic [7:0]  i_rd_addr,
	output logic      [15:0] o_rd_data,
	output logic             o_cycle_done,
	output logic             o_crc_err,
	output logic             o_line_err,
	output logic             o_running
);

	rsb_mst_s r;
	rsb_mst_s n;

	// output image is written by the user and read while the stream goes out
	logic [15:0] out_img [0:`RSB_IMG_WORDS-1];
	logic [15:0] in_img  [0:`RSB_IMG_WORDS-1];

	logic        tick;
	logic        rx_bit;
	logic        in_we;
	logic [7:0]  in_wa;
	logic [15:0] in_wd;
	logic [12:0] wlen;
	logic [12:0] total;
	logic [12:0] fk;
	logic [8:0]  fidx;
	logic        fbit;
	logic [5:0]  sc;
	logic [15:0] crc_nx;
	logic [8:0]  ridx;

	// slaves carry 8 words each; out of range counts are clamped to 1..32
	always_comb begin
		if (i_slave_cnt < `RSB_MIN_SLAVES) begin
			sc = `RSB_MIN_SLAVES;
		end else if (i_slave_cnt > `RSB_MAX_SLAVES) begin
			sc = `RSB_MAX_SLAVES;
		end else begin
			sc = i_slave_cnt;
		end
	end

	always_comb begin
		tick   = (r.st == RSB_M_SHIFT) && (r.div == `RSB_DIV_LAST);
		rx_bit = link.serial_rx_line;
		wlen   = {r.nw, 4'h0};
		total  = wlen + 13'h0010;
		// while the check word is worked out, the bit index skips the check word itself
		fk     = (r.st == RSB_M_CRC) ? (r.cnt + 13'h0010) : r.cnt;
		// stream bit k: check word first, then image words highest index first
		fidx   = r.nw - fk[12:4];
		if (fk < 13'h0010) begin
			fbit = r.crc[~fk[3:0]];
		end else begin
			fbit = out_img[fidx[7:0]][~fk[3:0]];
		end
		crc_nx = rsb_crc_step(r.crc, fbit);
		// returned words fill the input image highest index first
		ridx   = r.nw - r.cnt[12:4];
	end

	always_comb begin
		n      = r;
		n.done = 1'b0;
		in_we  = 1'b0;
		in_wa  = 8'h00;
		in_wd  = 16'h0000;

		case (r.st)
			RSB_M_IDLE: begin
				n.tx = `RSB_LINE_IDLE;
				if (i_run) begin
					n.nw  = {sc, 3'b000};
					n.cnt = 13'h0000;
					n.crc = `RSB_CRC_INIT;
					n.st  = RSB_M_CRC;
				end
			end

			// the check word covers the 8 image words of each configured slave before any bit leaves
			RSB_M_CRC: begin
				n.crc = crc_nx;
				n.cnt = r.cnt + 13'h0001;
				if (r.cnt == wlen - 13'h0001) begin
					n.st  = RSB_M_SHIFT;
					n.cnt = 13'h0001;
					n.div = 6'h00;
					n.bad = 1'b0;
					n.tx  = crc_nx[15];
				end
			end

			RSB_M_SHIFT: begin
				n.div = tick ? 6'h00 : r.div + 6'h01;
				// sample the return and launch the next bit on the same tick
				if (tick) begin
					n.rxw = {r.rxw[14:0], rx_bit};
					if (link.serial_rx_line == link.serial_rx_line_inverted) begin
						n.bad = 1'b1;
					end
					// every sixteenth tick up to the image length completes one input word; the last sixteen ticks bring the check word
					if ((r.cnt[3:0] == 4'h0) && (r.cnt <= wlen)) begin
						in_we = 1'b1;
						in_wa = ridx[7:0];
						in_wd = {r.rxw[14:0], rx_bit};
					end
					if (r.cnt == total) begin
						n.st = RSB_M_LATCH;
					end else begin
						n.tx  = fbit;
						n.cnt = r.cnt + 13'h0001;
					end
				end
			end

			// next cycle follows at once while running, otherwise slaves fall back
			RSB_M_LATCH: begin
				n.done     = 1'b1;
				// the returned check word must equal the one sent
				n.crc_err  = (r.rxw != r.crc);
				n.line_err = r.bad;
				if (i_run) begin
					n.nw  = {sc, 3'b000};
					n.cnt = 13'h0000;
					n.crc = `RSB_CRC_INIT;
					n.st  = RSB_M_CRC;
				end else begin
					n.st = RSB_M_FBK;
				end
			end

			RSB_M_FBK: begin
				n.st = RSB_M_IDLE;
			end

			default: begin
				n.st = RSB_M_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// writes during a cycle can tear a word against its check word
	always_ff @(posedge i_clk) begin
		if (i_wr_en) begin
			out_img[i_wr_addr] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (in_we) begin
			in_img[in_wa] <= in_wd;
		end
	end

	// registered read port of the input image
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rd_data <= 16'h0000;
		end else begin
			o_rd_data <= in_img[i_rd_addr];
		end
	end

	// link strobes are decoded from state, so all slaves act on the same edge
	assign link.data_out   = r.tx;
	assign link.data_out_n = ~r.tx;
	assign link.bit_tick   = tick;
	assign link.latch      = (r.st == RSB_M_LATCH);
	assign link.fallback   = (r.st == RSB_M_FBK);
	assign o_cycle_done    = r.done;
	assign o_crc_err       = r.crc_err;
	assign o_line_err      = r.line_err;
	assign o_running       = (r.st != RSB_M_IDLE);

endmodule

// ==== verification/rsb_link_asserts.sv ====
`timescale 1ns/100ps

module rsb_link_asserts (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic data_out,
	input wire logic data_out_n,
	input wire logic serial_rx_line,
	input wire logic serial_rx_line_inverted,
	input wire logic bit_tick,
	input wire logic latch,
	input wire logic fallback
);
	logic [15:0] gap_r;
	logic        fresh_r;

	// clocks since the last tick; fresh until the first tick of a cycle
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			gap_r   <= 16'h0000;
			fresh_r <= 1'h1;
		end else begin
			gap_r   <= bit_tick ? 16'h0000 : gap_r + 16'h0001;
			fresh_r <= latch ? 1'h1 : (bit_tick ? 1'h0 : fresh_r);
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_pulse(sig);
		sig ##1 !sig;
	endsequence

	a_tx_diff_pair: assert property (data_out_n == !data_out)
		else $error("tx pair not complementary");
	a_rx_diff_pair: assert property (bit_tick |-> serial_rx_line_inverted == !serial_rx_line)
		else $error("rx pair not complementary");
	a_bit_period: assert property (bit_tick && !fresh_r |-> gap_r == 16'h0031)
		else $error("tick spacing wrong");
	a_tick_latch_apart: assert property (!(bit_tick && latch))
		else $error("tick with latch");
	a_latch_pulse: assert property (latch |-> s_pulse(latch))
		else $error("latch too long");
	a_tx_hold: assert property (!$past(fresh_r) && !$past(bit_tick) && !$past(latch) |-> $stable(data_out))
		else $error("data moved between ticks");
	a_latch_after_tick: assert property (latch |-> !fresh_r && gap_r < 16'h0032)
		else $error("latch not after last tick");
	a_fallback_place: assert property (fallback |-> ($past(latch) || $past(latch, 2)) ##0 s_pulse(fallback))
		else $error("fallback misplaced");
endmodule

// ==== verification/tb_ring_shift_io_bus_master.sv ====
`timescale 1ns/100ps
`include "rsb_map.svh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, s); end end

module tb_ring_shift_io_bus_master;
	logic         i_clk = 1'h0;
	logic         i_rst_b = 1'h0;
	logic         i_run = 1'h0;
	logic         i_wr_en = 1'h0;
	logic [7:0]   i_wr_addr = 8'h00;
	logic [15:0]  i_wr_data = 16'h0000;
	logic [7:0]   i_rd_addr = 8'h00;
	logic [15:0]  o_rd_data;
	logic         o_cycle_done, o_crc_err, o_line_err, o_running;
	logic [127:0] in_w [2];
	logic [127:0] out_w [2];
	logic [127:0] fb_w;
	logic [15:0]  img [16];
	logic [1:0]   fb_en = 2'h1;
	logic [1:0]   fb_act, s_err;
	logic         cut = 1'h0;
	int           err_count = 0;
	int           n_tests = 0;
	int           ticks = 0;

	rsb_link_if lk [3] ();

	rsb_master i_rsb_master (.i_clk, .i_rst_b, .link(lk[0]), .i_run, .i_slave_cnt(6'h02), .i_wr_en, .i_wr_addr,
		.i_wr_data, .i_rd_addr, .o_rd_data, .o_cycle_done, .o_crc_err, .o_line_err, .o_running);

	for (genvar k = 0; k < 2; k++) begin : g_slv
		rsb_slave i_rsb_slave (.i_clk, .i_rst_b, .link(lk[k]), .i_in_words(in_w[k]), .i_fallback_en(fb_en[k]),
			.i_fallback_words(fb_w), .i_last((k == 1) && !cut), .o_out_words(out_w[k]),
			.o_fallback_active(fb_act[k]),
			.o_line_err(s_err[k]), .o_dn_data(lk[k+1].data_out), .o_dn_data_n(lk[k+1].data_out_n),
			.o_dn_tick(lk[k+1].bit_tick), .o_dn_latch(lk[k+1].latch), .o_dn_fallback(lk[k+1].fallback),
			.i_dn_ret(lk[k+1].serial_rx_line), .i_dn_ret_n(lk[k+1].serial_rx_line_inverted));
	end

	// open tail of the ring, read only while the last slave is told it is not last
	assign lk[2].serial_rx_line          = 1'h0;
	assign lk[2].serial_rx_line_inverted = 1'h1;

	rsb_link_asserts i_rsb_link_asserts (.i_clk, .i_rst_b, .data_out(lk[0].data_out),
		.data_out_n(lk[0].data_out_n), .serial_rx_line(lk[0].serial_rx_line),
		.serial_rx_line_inverted(lk[0].serial_rx_line_inverted), .bit_tick(lk[0].bit_tick),
		.latch(lk[0].latch), .fallback(lk[0].fallback));

	// image index of word j in the slave at position k+1
	function automatic int slot(int k, int j);
		return k * 8 + j;
	endfunction

	// reference check word: image words highest index first, msb first
	function automatic logic [15:0] exp_crc();
		logic [15:0] c;
		logic        f;
		c = `RSB_CRC_INIT;
		for (int w = 15; w >= 0; w--)
			for (int b = 15; b >= 0; b--) begin
				f = c[15] ^ img[w][b];
				c = {c[14:0], 1'h0} ^ (f ? `RSB_CRC_POLY : 16'h0000);
			end
		return c;
	endfunction

	task automatic conclude();
		$display("mismatches %0d of %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wait_done();
		@(posedge i_clk);
		#1;
		for (int n = 0; n < 15000 && o_cycle_done !== 1'h1; n++) begin
			@(posedge i_clk);
			#1;
		end
		`CHK("cycle done", 1'h1, o_cycle_done)
	endtask

	initial forever #20 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		ticks++;
		if (ticks == 60000) begin
			err_count++;
			conclude();
		end
	end

	initial begin
		void'($urandom(65));
		for (int k = 0; k < 2; k++)
			in_w[k] = {$urandom(), $urandom(), $urandom(), $urandom()};
		fb_w = {$urandom(), $urandom(), $urandom(), $urandom()};
		repeat (10) @(posedge i_clk);
		#1 i_rst_b = 1'h1;
		@(posedge i_clk);
		#1;
		`CHK("idle line", 1'h1, lk[0].data_out)
		for (int i = 0; i < 16; i++) begin
			img[i] = (i == 0) ? 16'h0000 : ((i == 15) ? 16'hFFFF : 16'($urandom()));
			i_wr_en = 1'h1;
			i_wr_addr = 8'(i);
			i_wr_data = img[i];
			@(posedge i_clk);
			#1;
		end
		i_wr_en = 1'h0;
		i_run = 1'h1;
		wait_done();
		i_run = 1'h0;
		`CHK("check word", 1'h0, o_crc_err)
		`CHK("no fallback", 2'h0, fb_act)
		for (int k = 0; k < 2; k++)
			for (int j = 0; j < 8; j++)
				`CHK("slave word", img[slot(k, j)], out_w[k][16*j +: 16])
		wait_done();
		`CHK("errors", 4'h0, {o_crc_err, o_line_err, s_err})
		for (int k = 0; k < 2; k++)
			for (int j = 0; j < 8; j++) begin
				i_rd_addr = 8'(slot(k, j));
				@(posedge i_clk);
				#1;
				`CHK("input word", in_w[k][16*j +: 16], o_rd_data)
			end
		`CHK("fallback", 3'h1, {o_running, fb_act})
		for (int j = 0; j < 8; j++) begin
			`CHK("fallback word", fb_w[16*j +: 16], out_w[0][16*j +: 16])
			`CHK("held word", img[slot(1, j)], out_w[1][16*j +: 16])
		end
		cut = 1'h1;
		i_run = 1'h1;
		@(posedge i_clk);
		#1;
		i_run = 1'h0;
		wait_done();
		`CHK("cut check word", 1'(exp_crc() != 16'h0000), o_crc_err)
		i_rd_addr = 8'(slot(1, 7));
		@(posedge i_clk);
		#1;
		`CHK("cut input word", 16'h0000, o_rd_data)
		conclude();
	end
endmodule
